// ==== bench/core_status_and_power_modes_bench.sv ====
/*
 * Self-checking bench for the core status word and power-mode block.
 * Assumes the datapath model drives every request port of the block.
 */
`timescale 1ns/100ps
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
	errorCnt++; $display("Error %s expected %h seen %h", nm, e, g); \
	end end
module core_status_and_power_modes_bench;
	import core_status_pkg::*;
	typedef struct {
		aluop_e     op;
		logic [7:0] a, b, o, ea, eb, ef;
		logic       c;
	} vec_s;
	logic       clk_sys = 1'b0;
	logic       rst = 1'b1;
	logic       irqWake = 1'b0;
	logic       wdtTimeout = 1'b0;
	logic       clkLossPin = 1'b0;
	logic [7:0] sfrAddr, sfrWrData, sfrRdData, bitAddr, aluOperand, rd;
	logic       sfrWrEn, sfrRdEn, bitWrEn, bitWrVal, aluValid, instrDone;
	aluop_e     aluOp;
	logic [7:0] accOut, bOut, pswOut, bankBase;
	logic       cpuRun, napActive, haltActive, oscStop, resetReq;
	int         errorCnt = 0;
	int         compares = 0;
	vec_s       vecs[9] = '{
		'{ALU_ADD,  8'hff, 8'h00, 8'h01, 8'h00, 8'h00, 8'hc0, 1'b0},
		'{ALU_ADD,  8'h7f, 8'h00, 8'h01, 8'h80, 8'h00, 8'h44, 1'b1},
		'{ALU_SUM_WITH_CARRY_OP, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00, 8'hc0, 1'b1},
		'{ALU_SUBTRACT_WITH_BORROW_OP, 8'h00, 8'h00, 8'h01, 8'hff, 8'h00, 8'hc0, 1'b0},
		'{ALU_SUBTRACT_WITH_BORROW_OP, 8'h80, 8'h00, 8'h01, 8'h7f, 8'h00, 8'h44, 1'b0},
		'{ALU_MUL,  8'h20, 8'h10, 8'h00, 8'h00, 8'h02, 8'h04, 1'b0},
		'{ALU_MUL,  8'h02, 8'h03, 8'h00, 8'h06, 8'h00, 8'h00, 1'b1},
		'{ALU_DIV,  8'h07, 8'h00, 8'h00, 8'h07, 8'h00, 8'h04, 1'b0},
		'{ALU_DIV,  8'h07, 8'h02, 8'h00, 8'h03, 8'h01, 8'h00, 1'b1}};

	core_status_power i_core_status_power (.clk_sys(clk_sys), .rst(rst),
		.sfrAddr(sfrAddr), .sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData),
		.sfrRdEn(sfrRdEn), .sfrRdData(sfrRdData), .bitWrEn(bitWrEn),
		.bitAddr(bitAddr), .bitWrVal(bitWrVal), .aluValid(aluValid),
		.aluOp(aluOp), .aluOperand(aluOperand), .instrDone(instrDone),
		.irqWake(irqWake), .wdtTimeout(wdtTimeout),
		.clkLossPin(clkLossPin), .accOut(accOut), .bOut(bOut),
		.pswOut(pswOut), .bankBase(bankBase), .cpuRun(cpuRun),
		.napActive(napActive), .haltActive(haltActive),
		.oscStop(oscStop), .resetReq(resetReq));

	datapath_model i_datapath_model (.clk_sys(clk_sys), .sfrAddr(sfrAddr),
		.sfrWrEn(sfrWrEn), .sfrWrData(sfrWrData), .sfrRdEn(sfrRdEn),
		.sfrRdData(sfrRdData), .bitWrEn(bitWrEn), .bitAddr(bitAddr),
		.bitWrVal(bitWrVal), .aluValid(aluValid), .aluOp(aluOp),
		.aluOperand(aluOperand), .instrDone(instrDone));

	always #5 clk_sys = ~clk_sys;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	task automatic tick();
		@(posedge clk_sys);
		#1;
	endtask

	task automatic pulse_rst();
		rst = 1'b1;
		repeat (2) tick();
		rst = 1'b0;
	endtask

	task automatic complete_run();
		$display("compares %0d mismatches %0d", compares, errorCnt);
		if (errorCnt == 0 && compares > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Scenarios
	// ------------------------------------------------------------------
	task automatic t_reset();
		logic [7:0] adr[5] = '{POWER_CONTROL_ADDR, STATUS_WORD_ADDR,
			MAIN_WORKING_ADDR, SECOND_OPERAND_ADDR, 8'h88};
		`CHK("cpuRun", 1'b1, cpuRun)
		foreach (adr[i]) begin
			i_datapath_model.rd_byte(adr[i], rd);
			`CHK("reset read", 8'h00, rd)
		end
		$display("reset values test done");
	endtask

	task automatic t_arith();
		foreach (vecs[i]) begin
			i_datapath_model.wr_byte(MAIN_WORKING_ADDR, vecs[i].a, 1'b0);
			i_datapath_model.wr_byte(SECOND_OPERAND_ADDR, vecs[i].b, 1'b0);
			i_datapath_model.wr_byte(STATUS_WORD_ADDR, {vecs[i].c, 7'h0}, 1'b0);
			i_datapath_model.alu(vecs[i].op, vecs[i].o);
			`CHK("accOut", vecs[i].ea, accOut)
			`CHK("bOut", vecs[i].eb, bOut)
			`CHK("pswOut", vecs[i].ef | 8'(^vecs[i].ea), pswOut)
		end
		$display("arithmetic flags test done");
	endtask

	task automatic t_bits();
		i_datapath_model.wr_byte(MAIN_WORKING_ADDR, 8'h00, 1'b0);
		for (int k = 0; k < 4; k++) begin
			i_datapath_model.wr_byte(STATUS_WORD_ADDR, 8'(k * 8 + 1), 1'b0);
			`CHK("bankBase", 8'(k * 8), bankBase)
			`CHK("pswOut", 8'(k * 8), pswOut)
		end
		i_datapath_model.wr_byte(STATUS_WORD_ADDR, 8'h00, 1'b0);
		i_datapath_model.wr_bit({STATUS_WORD_ADDR[7:3], 3'd5}, 1'b1);
		i_datapath_model.wr_bit({STATUS_WORD_ADDR[7:3], 3'd1}, 1'b1);
		i_datapath_model.wr_bit({MAIN_WORKING_ADDR[7:3], 3'd7}, 1'b1);
		i_datapath_model.wr_bit({SECOND_OPERAND_ADDR[7:3], 3'd0}, 1'b1);
		`CHK("accOut", 8'h80, accOut)
		`CHK("bOut", 8'h01, bOut)
		`CHK("pswOut", 8'h23, pswOut)
		i_datapath_model.alu(ALU_ADD, 8'h01);
		`CHK("accOut", 8'h81, accOut)
		`CHK("pswOut", 8'h22, pswOut)
		i_datapath_model.rd_byte(MAIN_WORKING_ADDR, rd);
		`CHK("acc read", 8'h81, rd)
		i_datapath_model.rd_byte(STATUS_WORD_ADDR, rd);
		`CHK("status read", 8'h22, rd)
		$display("bit and bank test done");
	endtask

	task automatic t_nap();
		i_datapath_model.wr_byte(POWER_CONTROL_ADDR, 8'h01, 1'b1);
		tick();
		`CHK("napActive", 1'b1, napActive)
		`CHK("cpuRun", 1'b0, cpuRun)
		i_datapath_model.alu(ALU_ADD, 8'h01);
		`CHK("accOut", 8'h81, accOut)
		irqWake = 1'b1;
		tick();
		irqWake = 1'b0;
		tick();
		`CHK("cpuRun", 1'b1, cpuRun)
		`CHK("napActive", 1'b0, napActive)
		i_datapath_model.rd_byte(POWER_CONTROL_ADDR, rd);
		`CHK("power read", 8'h00, rd)
		i_datapath_model.wr_byte(POWER_CONTROL_ADDR, 8'h01, 1'b1);
		wdtTimeout = 1'b1;
		tick();
		wdtTimeout = 1'b0;
		tick();
		`CHK("resetReq", 1'b1, resetReq)
		pulse_rst();
		`CHK("napActive", 1'b0, napActive)
		`CHK("accOut", 8'h00, accOut)
		$display("nap test done");
	endtask

	task automatic t_halt();
		i_datapath_model.wr_byte(POWER_CONTROL_ADDR, 8'h03, 1'b1);
		tick();
		`CHK("haltActive", 1'b1, haltActive)
		`CHK("oscStop", 1'b1, oscStop)
		`CHK("napActive", 1'b0, napActive)
		irqWake = 1'b1;
		repeat (2) tick();
		irqWake = 1'b0;
		tick();
		`CHK("cpuRun", 1'b0, cpuRun)
		`CHK("haltActive", 1'b1, haltActive)
		clkLossPin = 1'b1;
		repeat (5) tick();
		`CHK("resetReq", 1'b1, resetReq)
		clkLossPin = 1'b0;
		pulse_rst();
		`CHK("haltActive", 1'b0, haltActive)
		`CHK("cpuRun", 1'b1, cpuRun)
		$display("deep halt test done");
	endtask

	initial begin
		repeat (6) @(posedge clk_sys);
		#1;
		rst = 1'b0;
		t_reset();
		t_arith();
		t_bits();
		t_nap();
		t_halt();
		complete_run();
	end

	// The tests need under two microseconds; this cuts a hang short.
	initial begin
		#100000;
		errorCnt++;
		complete_run();
	end
endmodule

// ==== bench/datapath_model.sv ====
/*
 * Behavioural model of the core datapath that issues register and
 * arithmetic requests to the status and power-mode block.
 * Assumes the bench calls its tasks one at a time, in the clk_sys domain.
 */
`timescale 1ns/100ps
module datapath_model (
	input  wire logic               clk_sys,    // system clock
	output logic [7:0]              sfrAddr,    // register address
	output logic                    sfrWrEn,    // byte write strobe
	output logic [7:0]              sfrWrData,  // byte write data
	output logic                    sfrRdEn,    // byte read strobe
	input  wire logic [7:0]         sfrRdData,  // byte read data
	output logic                    bitWrEn,    // bit write strobe
	output logic [7:0]              bitAddr,    // bit address
	output logic                    bitWrVal,   // bit write value
	output logic                    aluValid,   // arithmetic step
	output core_status_pkg::aluop_e aluOp,      // arithmetic op
	output logic [7:0]              aluOperand, // second operand
	output logic                    instrDone   // instruction ends
);
	import core_status_pkg::*;

	initial begin
		{sfrWrEn, sfrRdEn, bitWrEn, bitWrVal, aluValid, instrDone} = '0;
		{sfrAddr, sfrWrData, bitAddr, aluOperand} = '0;
		aluOp = ALU_ADD;
	end

	// ------------------------------------------------------------------
	// Request tasks
	// ------------------------------------------------------------------
	task automatic begin_req();
		@(posedge clk_sys);
		#1;
	endtask

	// Released address, data and operand buses show the inverse of their last value, so the block
	// cannot pass by latching stale data outside a strobe.
	task automatic end_req();
		@(posedge clk_sys);
		#1;
		{sfrWrEn, sfrRdEn, bitWrEn, aluValid, instrDone} = '0;
		sfrAddr = ~sfrAddr;
		sfrWrData = ~sfrWrData;
		bitAddr = ~bitAddr;
		aluOperand = ~aluOperand;
	endtask

	task automatic wr_byte(input logic [7:0] a, input logic [7:0] d,
		input logic done);
		begin_req();
		{sfrAddr, sfrWrData, instrDone, sfrWrEn} = {a, d, done, 1'b1};
		end_req();
	endtask

	task automatic rd_byte(input logic [7:0] a, output logic [7:0] d);
		begin_req();
		{sfrAddr, sfrRdEn} = {a, 1'b1};
		end_req();
		d = sfrRdData;
	endtask

	task automatic wr_bit(input logic [7:0] a, input logic v);
		begin_req();
		{bitAddr, bitWrVal, bitWrEn} = {a, v, 1'b1};
		end_req();
	endtask

	task automatic alu(input aluop_e op, input logic [7:0] o);
		begin_req();
		aluOp = op;
		{aluOperand, aluValid} = {o, 1'b1};
		end_req();
	endtask
endmodule

// ==== core/core_status_pkg.sv ====
/*
 * Constants shared by the core status, accumulator and power-mode block:
 * special-register addresses, field positions, reset values, arithmetic
 * operation codes and power-mode states.
 * Assumes an 8-bit special-register space addressed by the core datapath.
 */
package core_status_pkg;

	// ------------------------------------------------------------------
	// Register addresses
	// ------------------------------------------------------------------
	localparam logic [7:0] POWER_CONTROL_ADDR   = 8'h87;
	localparam logic [7:0] STATUS_WORD_ADDR     = 8'hd0;
	localparam logic [7:0] MAIN_WORKING_ADDR    = 8'he0;
	localparam logic [7:0] SECOND_OPERAND_ADDR  = 8'hf0;

	// ------------------------------------------------------------------
	// Reset values
	// ------------------------------------------------------------------
	localparam logic [7:0] POWER_CONTROL_RST    = 8'h00;
	localparam logic [7:0] STATUS_WORD_RST      = 8'h00;
	localparam logic [7:0] MAIN_WORKING_RST     = 8'h00;
	localparam logic [7:0] SECOND_OPERAND_RST   = 8'h00;
	localparam logic [15:0] RESTART_VECTOR      = 16'h0000;

	// ------------------------------------------------------------------
	// Status word fields
	// ------------------------------------------------------------------
	localparam int CARRY_OUT_BIT    = 7;
	localparam int HALF_CARRY_BIT   = 6;
	localparam int USER_ZERO_BIT    = 5;
	localparam int BANK_HIGH_BIT    = 4;
	localparam int BANK_LOW_BIT     = 3;
	localparam int SIGN_WRAP_BIT    = 2;
	localparam int USER_ONE_BIT     = 1;
	localparam int ODD_ONES_BIT     = 0;

	// ------------------------------------------------------------------
	// Power control fields
	// ------------------------------------------------------------------
	localparam int DEEP_HALT_BIT    = 1;
	localparam int CPU_NAP_BIT      = 0;
	localparam logic [5:0] POWER_CONTROL_RESERVED_RST = 6'h00;

	// ------------------------------------------------------------------
	// Operations and states
	// ------------------------------------------------------------------
	typedef enum logic [2:0] {
		ALU_ADD  = 3'h0,
		ALU_SUM_WITH_CARRY_OP = 3'h1,
		ALU_SUBTRACT_WITH_BORROW_OP = 3'h2,
		ALU_MUL  = 3'h3,
		ALU_DIV  = 3'h4
	} aluop_e;

	typedef enum logic [1:0] {
		PWR_RUN  = 2'h0,
		PWR_NAP  = 2'h1,
		PWR_HALT = 2'h2
	} pwr_e;

endpackage

// ==== core/core_status_power.sv ====
/*
 * Status word, accumulator pair and power-mode control of an 8-bit core.
 * Assumes the datapath issues one arithmetic step or register access per
 * cycle on clk_sys, and that resetReq is routed back into rst.
 */
`timescale 1ns/100ps
module core_status_power (
	input  wire logic                    clk_sys,      // system clock
	input  wire logic                    rst,          // async reset
	input  wire logic [7:0]              sfrAddr,      // register address
	input  wire logic                    sfrWrEn,      // byte write strobe
	input  wire logic [7:0]              sfrWrData,    // byte write data
	input  wire logic                    sfrRdEn,      // byte read strobe
	output logic      [7:0]              sfrRdData,    // byte read data
	input  wire logic                    bitWrEn,      // bit write strobe
	input  wire logic [7:0]              bitAddr,      // bit address
	input  wire logic                    bitWrVal,     // bit write value
	input  wire logic                    aluValid,     // arithmetic step
	input  wire core_status_pkg::aluop_e aluOp,        // arithmetic op
	input  wire logic [7:0]              aluOperand,   // second operand
	input  wire logic                    instrDone,    // instruction ends
	input  wire logic                    irqWake,      // enabled irq
	input  wire logic                    wdtTimeout,   // watchdog expiry
	input  wire logic                    clkLossPin,   // clock loss input
	output logic      [7:0]              accOut,       // main register
	output logic      [7:0]              bOut,         // second register
	output logic      [7:0]              pswOut,       // status word
	output logic      [7:0]              bankBase,     // bank base address
	output logic                         cpuRun,       // core may execute
	output logic                         napActive,    // nap state
	output logic                         haltActive,   // deep halt state
	output logic                         oscStop,      // stop oscillator
	output logic                         resetReq      // internal reset
);
	import core_status_pkg::*;

	// ------------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------------
	function automatic logic [7:0] putBit(input logic [7:0] v,
	                                      input logic [2:0] idx,
	                                      input logic       b);
		logic [7:0] r;
		r = v;
		r[idx] = b;
		return r;
	endfunction

	function automatic logic hitsByte(input logic [7:0] bitA,
	                                  input logic [7:0] byteA);
		return {bitA[7:3], 3'h0} == byteA;
	endfunction

	// ------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------
	logic [7:0] acc_ff;
	logic [7:0] nxt_acc;
	logic [7:0] b_ff;
	logic [7:0] nxt_b;
	logic [7:0] psw_ff;
	logic [7:0] nxt_psw;
	logic [7:0] bank_ff;
	logic [7:0] nxt_bank;
	logic [5:0] rsvd_ff;
	logic [5:0] nxt_rsvd;
	logic [7:0] rd_ff;
	logic [7:0] nxt_rd;
	logic       aluGo;
	logic [8:0] sum9;
	logic [4:0] low5;
	logic [15:0] prod16;
	logic       cin;

	assign aluGo = aluValid && cpuRun;

	always_comb begin
		nxt_acc  = acc_ff;
		nxt_b    = b_ff;
		nxt_psw  = psw_ff;
		nxt_rsvd = rsvd_ff;
		sum9     = 9'h000;
		low5     = 5'h00;
		prod16   = 16'h0000;
		cin      = 1'b0;
		if (sfrWrEn) begin
			case (sfrAddr)
				MAIN_WORKING_ADDR:   nxt_acc = sfrWrData;
				SECOND_OPERAND_ADDR: nxt_b = sfrWrData;
				STATUS_WORD_ADDR:    nxt_psw = sfrWrData;
				POWER_CONTROL_ADDR:  nxt_rsvd = sfrWrData[7:2];
				default:             nxt_acc = acc_ff;
			endcase
		end
		if (bitWrEn && hitsByte(bitAddr, MAIN_WORKING_ADDR)) begin
			nxt_acc = putBit(acc_ff, bitAddr[2:0], bitWrVal);
		end
		if (bitWrEn && hitsByte(bitAddr, SECOND_OPERAND_ADDR)) begin
			nxt_b = putBit(b_ff, bitAddr[2:0], bitWrVal);
		end
		if (bitWrEn && hitsByte(bitAddr, STATUS_WORD_ADDR)) begin
			nxt_psw = putBit(psw_ff, bitAddr[2:0], bitWrVal);
		end
		// An arithmetic step owns the flags it produces, so it wins over
		// a register write in the same cycle.
		if (aluGo) begin
			case (aluOp)
				ALU_ADD, ALU_SUM_WITH_CARRY_OP: begin
					cin = (aluOp == ALU_SUM_WITH_CARRY_OP) ? psw_ff[CARRY_OUT_BIT] : 1'b0;
					sum9 = {1'b0, acc_ff} + {1'b0, aluOperand} + {8'h00, cin};
					low5 = {1'b0, acc_ff[3:0]} + {1'b0, aluOperand[3:0]}
					     + {4'h0, cin};
					nxt_acc = sum9[7:0];
					nxt_psw[CARRY_OUT_BIT] = sum9[8];
					nxt_psw[HALF_CARRY_BIT] = low5[4];
					nxt_psw[SIGN_WRAP_BIT] = (acc_ff[7] == aluOperand[7])
					                      && (sum9[7] != acc_ff[7]);
				end
				ALU_SUBTRACT_WITH_BORROW_OP: begin
					cin = psw_ff[CARRY_OUT_BIT];
					sum9 = {1'b0, acc_ff} - {1'b0, aluOperand} - {8'h00, cin};
					low5 = {1'b0, acc_ff[3:0]} - {1'b0, aluOperand[3:0]}
					     - {4'h0, cin};
					nxt_acc = sum9[7:0];
					nxt_psw[CARRY_OUT_BIT] = sum9[8];
					nxt_psw[HALF_CARRY_BIT] = low5[4];
					nxt_psw[SIGN_WRAP_BIT] = (acc_ff[7] != aluOperand[7])
					                      && (sum9[7] != acc_ff[7]);
				end
				ALU_MUL: begin
					prod16 = {8'h00, acc_ff} * {8'h00, b_ff};
					nxt_acc = prod16[7:0];
					nxt_b = prod16[15:8];
					nxt_psw[CARRY_OUT_BIT] = 1'b0;
					nxt_psw[HALF_CARRY_BIT] = 1'b0;
					nxt_psw[SIGN_WRAP_BIT] = |prod16[15:8];
				end
				ALU_DIV: begin
					nxt_psw[CARRY_OUT_BIT] = 1'b0;
					nxt_psw[HALF_CARRY_BIT] = 1'b0;
					nxt_psw[SIGN_WRAP_BIT] = (b_ff == 8'h00);
					if (b_ff != 8'h00) begin
						nxt_acc = acc_ff / b_ff;
						nxt_b = acc_ff % b_ff;
					end
				end
				default: begin
					nxt_psw[CARRY_OUT_BIT] = 1'b0;
					nxt_psw[HALF_CARRY_BIT] = 1'b0;
				end
			endcase
		end
		nxt_psw[ODD_ONES_BIT] = ^nxt_acc;
		nxt_bank = {3'h0, nxt_psw[BANK_HIGH_BIT], nxt_psw[BANK_LOW_BIT],
		            3'h0};
		nxt_rd = 8'h00;
		if (sfrRdEn) begin
			case (sfrAddr)
				MAIN_WORKING_ADDR:   nxt_rd = acc_ff;
				SECOND_OPERAND_ADDR: nxt_rd = b_ff;
				STATUS_WORD_ADDR:    nxt_rd = psw_ff;
				POWER_CONTROL_ADDR:  nxt_rd = {rsvd_ff, 2'h0};
				default:             nxt_rd = 8'h00;
			endcase
		end
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			acc_ff  <= MAIN_WORKING_RST;
			b_ff    <= SECOND_OPERAND_RST;
			psw_ff  <= STATUS_WORD_RST;
			bank_ff <= 8'h00;
			rsvd_ff <= POWER_CONTROL_RESERVED_RST;
			rd_ff   <= 8'h00;
		end else begin
			acc_ff  <= nxt_acc;
			b_ff    <= nxt_b;
			psw_ff  <= nxt_psw;
			bank_ff <= nxt_bank;
			rsvd_ff <= nxt_rsvd;
			rd_ff   <= nxt_rd;
		end
	end

	assign accOut    = acc_ff;
	assign bOut      = b_ff;
	assign pswOut    = psw_ff;
	assign bankBase  = bank_ff;
	assign sfrRdData = rd_ff;

	// ------------------------------------------------------------------
	// Power modes
	// ------------------------------------------------------------------
	// The clock-loss line comes from a detector with its own clock.
	logic  lossMeta_ff;
	logic  lossSync_ff;
	pwr_e  state_ff;
	pwr_e  nxt_state;
	logic  napPend_ff;
	logic  nxt_napPend;
	logic  haltPend_ff;
	logic  nxt_haltPend;
	logic  rstReq_ff;
	logic  nxt_rstReq;
	logic  run_ff;
	logic  nap_ff;
	logic  halt_ff;
	logic  pconWr;
	logic  wantNap;
	logic  wantHalt;

	assign pconWr   = sfrWrEn && (sfrAddr == POWER_CONTROL_ADDR);
	assign wantNap  = napPend_ff || (pconWr && sfrWrData[CPU_NAP_BIT]);
	assign wantHalt = haltPend_ff || (pconWr && sfrWrData[DEEP_HALT_BIT]);

	always_comb begin
		nxt_state    = state_ff;
		nxt_napPend  = wantNap;
		nxt_haltPend = wantHalt;
		nxt_rstReq   = rstReq_ff || wdtTimeout || lossSync_ff;
		case (state_ff)
			PWR_RUN: begin
				if (instrDone && wantHalt) begin
					nxt_state    = PWR_HALT;
					nxt_haltPend = 1'b0;
					nxt_napPend  = 1'b0;
				end else if (instrDone && wantNap) begin
					nxt_state   = PWR_NAP;
					nxt_napPend = 1'b0;
				end
			end
			PWR_NAP: begin
				if (irqWake) begin
					nxt_state = PWR_RUN;
				end
			end
			PWR_HALT: begin
				nxt_state = PWR_HALT;
			end
			default: nxt_state = PWR_RUN;
		endcase
	end

	always_ff @(posedge clk_sys or posedge rst) begin
		if (rst) begin
			lossMeta_ff <= 1'b0;
			lossSync_ff <= 1'b0;
			state_ff    <= PWR_RUN;
			napPend_ff  <= 1'b0;
			haltPend_ff <= 1'b0;
			rstReq_ff   <= 1'b0;
			run_ff      <= 1'b1;
			nap_ff      <= 1'b0;
			halt_ff     <= 1'b0;
		end else begin
			lossMeta_ff <= clkLossPin;
			lossSync_ff <= lossMeta_ff;
			state_ff    <= nxt_state;
			napPend_ff  <= nxt_napPend;
			haltPend_ff <= nxt_haltPend;
			rstReq_ff   <= nxt_rstReq;
			run_ff      <= (nxt_state == PWR_RUN);
			nap_ff      <= (nxt_state == PWR_NAP);
			halt_ff     <= (nxt_state == PWR_HALT);
		end
	end

	assign cpuRun     = run_ff;
	assign napActive  = nap_ff;
	assign haltActive = halt_ff;
	assign oscStop    = halt_ff;
	assign resetReq   = rstReq_ff;

	// ------------------------------------------------------------------
	// Checks
	// ------------------------------------------------------------------
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst);

	a_parity_follows: assert property (
		pswOut[ODD_ONES_BIT] == ^accOut)
		else $error("parity flag does not match accumulator");

	a_add_carry: assert property (
		(cpuRun && aluValid && aluOp == ALU_ADD) |=>
		pswOut[CARRY_OUT_BIT] ==
		((9'($past(accOut)) + 9'($past(aluOperand))) > 9'h0ff))
		else $error("carry wrong after add");

	a_mul_wrap: assert property (
		(cpuRun && aluValid && aluOp == ALU_MUL) |=>
		pswOut[SIGN_WRAP_BIT] == (bOut != 8'h00))
		else $error("overflow wrong after product");

	a_div_zero: assert property (
		(cpuRun && aluValid && aluOp == ALU_DIV && bOut == 8'h00) |=>
		pswOut[SIGN_WRAP_BIT] && $stable(accOut))
		else $error("zero divisor not flagged");

	a_div_clear: assert property (
		(cpuRun && aluValid && aluOp == ALU_DIV && bOut != 8'h00) |=>
		!pswOut[SIGN_WRAP_BIT])
		else $error("overflow not cleared by divide");

	a_user_flags: assert property (
		!(sfrWrEn && sfrAddr == STATUS_WORD_ADDR) &&
		!(bitWrEn && hitsByte(bitAddr, STATUS_WORD_ADDR)) |=>
		$stable(pswOut[USER_ZERO_BIT]) && $stable(pswOut[USER_ONE_BIT]))
		else $error("user flag changed by hardware");

	a_bank_base: assert property (
		bankBase == {3'h0, pswOut[BANK_HIGH_BIT:BANK_LOW_BIT], 3'h0})
		else $error("bank base does not match select bits");

	a_power_control_zero: assert property (
		(sfrRdEn && sfrAddr == POWER_CONTROL_ADDR) |=>
		sfrRdData[DEEP_HALT_BIT:CPU_NAP_BIT] == 2'h0)
		else $error("power request bits read nonzero");

	a_nap_entry: assert property (
		(cpuRun && instrDone && wantNap && !wantHalt) |=>
		napActive && !cpuRun ##1 !cpuRun)
		else $error("nap not entered after instruction");

	a_nap_wake: assert property (
		(napActive && irqWake) |=> cpuRun && !napActive)
		else $error("interrupt did not end nap");

	a_halt_prio: assert property (
		(cpuRun && instrDone && wantHalt && wantNap) |=>
		haltActive && !napActive)
		else $error("deep halt lost priority");

	a_halt_hold: assert property (
		haltActive && irqWake |=> haltActive [*3])
		else $error("deep halt left without reset");

	a_wdt_reset: assert property (
		wdtTimeout |=> resetReq)
		else $error("watchdog expiry gave no reset request");

endmodule
